// ---- pdc_defines.svh ----
`ifndef PDC_DEFINES_SVH
`define PDC_DEFINES_SVH

// Unit halt control bit positions.
`define PDC_HALT_ADC_BIT 0
`define PDC_HALT_SER1_BIT 3
`define PDC_HALT_SER0_BIT 4
`define PDC_HALT_TMR_BIT 5
`define PDC_CLK_PIN_DISABLE_BIT 7

// Reset value and writable halt bit mask.
`define PDC_HALT_CTRL_RST 8'h00
`define PDC_HALT_MASK 8'h39

// Read data returned by a halted peripheral.
`define PDC_HALTED_RDATA 8'hFF

`endif

// ---- pdc_pkg.sv ----
package pdc_pkg;

    // ************************************************************
    // Operating modes
    // ************************************************************
    typedef enum logic [4:0] {
        PDC_RUN = 5'b00001,
        PDC_SLEEP = 5'b00010,
        PDC_SW_DEEP_SLEEP_PIN_N = 5'b00100,
        PDC_HW_DEEP_SLEEP_PIN_N = 5'b01000,
        PDC_OSC_WAIT = 5'b10000
    } pdc_mode_e;

    // Peripheral bus access from the processor.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] unit;
        logic [7:0] wdata;
    } pdc_acc_s;

    // Per-unit control outputs.
    typedef struct packed {
        logic [3:0] halt;
        logic [3:0] init;
        logic [3:0] pin_release;
    } pdc_unit_s;

endpackage : pdc_pkg

// ---- pdc_pin_sync.sv ----
`timescale 1ns/1ns
`default_nettype none

module pdc_pin_sync (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Pins
    input wire logic [4:0] pin_i,
    output logic [4:0] pin_o
);
    logic [4:0] meta_q;
    logic [4:0] sync_q;

    // Pins idle high, so reset to the released level.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            meta_q <= 5'h1F;
            sync_q <= 5'h1F;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
        end
    end

    assign pin_o = sync_q;
endmodule // pdc_pin_sync

`default_nettype wire

// ---- power_down_control.sv ----
// Summary of operation
// - Deep-sleep pin low enters hardware standby always.
// - Hardware standby halts all, resets except RAM.
// - Hardware standby floats all port pins.
// - Deep-sleep rising with init low restarts oscillator.
// - Init rising runs reset handling, then execution.
// - Halt bit set halts unit next bus cycle.
// - Halt bits 5..3 and 0 for four units.
// - Halted unit reads FF, ignores writes.
// - Halting a unit initialises all its registers.
// - Halted unit releases its pins to port.
// - Clock stop bit floats the clock pin.
// - Clock pin: float, high, or clock by mode.
// - Software standby holds port states unchanged.
// - Software standby stops CPU, clock, peripherals.
`timescale 1ns/1ns
`default_nettype none
`include "pdc_defines.svh"

module power_down_control (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Board pins
    input wire logic deep_sleep_pin_n_i,
    input wire logic chip_init_pin_n_i,
    input wire logic [2:0] boot_config_pins_i,
    // Processor side
    input wire logic sleep_req_i,
    input wire logic sw_deep_sleep_pin_n_req_i,
    input wire logic wake_i,
    input wire logic halt_ctrl_wr_i,
    input wire logic [7:0] halt_ctrl_wdata_i,
    input wire pdc_pkg::pdc_acc_s unit_acc_i,
    input wire logic phi_i,
    // Status and control outputs
    output logic [7:0] unit_halt_control_o,
    output pdc_pkg::pdc_mode_e mode_o,
    output logic [2:0] boot_config_o,
    output logic cpu_halt_o,
    output logic cpu_reset_o,
    output logic reset_exception_o,
    output logic osc_run_o,
    output logic ports_hiz_o,
    output logic ports_hold_o,
    output logic ram_keep_o,
    output pdc_pkg::pdc_unit_s unit_o,
    output logic unit_wr_o,
    output logic unit_rd_o,
    output logic [7:0] unit_rdata_force_o,
    output logic unit_rdata_forced_o,
    // Clock pin
    output logic clk_pin_o,
    output logic clk_pin_oe_o
);
    import pdc_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        pdc_mode_e mode;
        logic [7:0] ctrl;
        logic init_prev;
        logic [2:0] boot;
        logic cpu_halt;
        logic cpu_reset;
        logic rst_exc;
        logic osc_run;
        logic hiz;
        logic hold;
        logic ram_keep;
        pdc_unit_s unit;
        logic wr;
        logic rd;
        logic forced;
        logic clk_pin;
        logic clk_oe;
    } pdc_state_s;

    pdc_state_s st_q;
    pdc_state_s st_d;
    logic [4:0] pins;
    logic deep_sleep_pin_n_n;
    logic init_n;
    logic [3:0] halt_new;

    pdc_pin_sync u_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i({boot_config_pins_i, chip_init_pin_n_i, deep_sleep_pin_n_i}),
        .pin_o(pins)
    );
    assign deep_sleep_pin_n_n = pins[0];
    assign init_n = pins[1];

    // Maps a control byte onto the four unit halt flags.
    function automatic logic [3:0] pdc_halts(input logic [7:0] c);
        pdc_halts = {c[`PDC_HALT_TMR_BIT], c[`PDC_HALT_SER0_BIT],
            c[`PDC_HALT_SER1_BIT], c[`PDC_HALT_ADC_BIT]};
    endfunction

    assign halt_new = pdc_halts(st_q.ctrl);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_d = st_q;
        st_d.init_prev = init_n;
        st_d.rst_exc = 1'b0;
        st_d.unit.init = 4'h0;
        unique case (st_q.mode)
            PDC_RUN: begin
                if (sw_deep_sleep_pin_n_req_i) begin
                    st_d.mode = PDC_SW_DEEP_SLEEP_PIN_N;
                end else if (sleep_req_i) begin
                    st_d.mode = PDC_SLEEP;
                end
            end
            PDC_SLEEP: begin
                if (wake_i) begin
                    st_d.mode = PDC_RUN;
                end
            end
            PDC_SW_DEEP_SLEEP_PIN_N: begin
                if (wake_i) begin
                    st_d.mode = PDC_RUN;
                end
            end
            PDC_HW_DEEP_SLEEP_PIN_N: begin
                if (deep_sleep_pin_n_n && !init_n) begin
                    st_d.mode = PDC_OSC_WAIT;
                end
            end
            PDC_OSC_WAIT: begin
                if (init_n && !st_q.init_prev) begin
                    st_d.mode = PDC_RUN;
                    st_d.rst_exc = 1'b1;
                end
            end
            default: st_d.mode = PDC_RUN;
        endcase
        // Reset pin low outside hardware standby and oscillator wait returns to run under reset.
        if (!init_n && st_d.mode != PDC_HW_DEEP_SLEEP_PIN_N &&
            st_d.mode != PDC_OSC_WAIT) begin
            st_d.mode = PDC_RUN;
        end
        if (!deep_sleep_pin_n_n) begin
            st_d.mode = PDC_HW_DEEP_SLEEP_PIN_N;
        end
        // Processor writes only land while running.
        if (halt_ctrl_wr_i && st_q.mode == PDC_RUN && init_n) begin
            st_d.ctrl = halt_ctrl_wdata_i & (`PDC_HALT_MASK |
                (8'h01 << `PDC_CLK_PIN_DISABLE_BIT));
        end
        if (st_d.mode == PDC_HW_DEEP_SLEEP_PIN_N || st_d.mode == PDC_OSC_WAIT) begin
            st_d.ctrl = `PDC_HALT_CTRL_RST;
        end
        // The new halt takes effect one cycle after the write.
        st_d.unit.init = halt_new & ~st_q.unit.halt;
        st_d.unit.halt = halt_new;
        st_d.unit.pin_release = halt_new;
        if (st_d.mode inside {PDC_HW_DEEP_SLEEP_PIN_N, PDC_OSC_WAIT, PDC_SW_DEEP_SLEEP_PIN_N}) begin
            st_d.unit.init = 4'hF;
        end
        st_d.cpu_halt = st_d.mode != PDC_RUN;
        st_d.cpu_reset = st_d.mode inside {PDC_HW_DEEP_SLEEP_PIN_N, PDC_OSC_WAIT} ||
            !init_n;
        st_d.osc_run = st_d.mode inside {PDC_RUN, PDC_SLEEP, PDC_OSC_WAIT};
        st_d.hiz = st_d.mode inside {PDC_HW_DEEP_SLEEP_PIN_N, PDC_OSC_WAIT};
        st_d.hold = st_d.mode == PDC_SW_DEEP_SLEEP_PIN_N;
        // RAM is never reset here; keep is raised only in hardware standby, oscillator wait and software standby.
        st_d.ram_keep = st_d.hiz || st_d.hold;
        if (st_d.mode != PDC_HW_DEEP_SLEEP_PIN_N && st_d.mode != PDC_OSC_WAIT) begin
            st_d.boot = pins[4:2];
        end
        // A halted unit's register port reads FF and drops writes.
        st_d.forced = halt_new[unit_acc_i.unit] &&
            (unit_acc_i.rd || unit_acc_i.wr);
        st_d.wr = unit_acc_i.wr && !halt_new[unit_acc_i.unit];
        st_d.rd = unit_acc_i.rd && !halt_new[unit_acc_i.unit];
        // Clock pin behaviour per mode and stop bit.
        st_d.clk_oe = !st_d.ctrl[`PDC_CLK_PIN_DISABLE_BIT] &&
            !st_d.hiz;
        st_d.clk_pin = (st_d.mode == PDC_SW_DEEP_SLEEP_PIN_N) ? 1'b1 : phi_i;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_q <= '{mode: PDC_RUN, ctrl: `PDC_HALT_CTRL_RST,
                init_prev: 1'b1, boot: 3'h0, cpu_halt: 1'b0,
                cpu_reset: 1'b1, rst_exc: 1'b0, osc_run: 1'b1,
                hiz: 1'b0, hold: 1'b0, ram_keep: 1'b0, unit: '0,
                wr: 1'b0, rd: 1'b0,
                forced: 1'b0, clk_pin: 1'b0, clk_oe: 1'b1};
        end else begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign unit_halt_control_o = st_q.ctrl;
    assign mode_o = st_q.mode;
    assign boot_config_o = st_q.boot;
    assign cpu_halt_o = st_q.cpu_halt;
    assign cpu_reset_o = st_q.cpu_reset;
    assign reset_exception_o = st_q.rst_exc;
    assign osc_run_o = st_q.osc_run;
    assign ports_hiz_o = st_q.hiz;
    assign ports_hold_o = st_q.hold;
    assign ram_keep_o = st_q.ram_keep;
    assign unit_o = st_q.unit;
    assign unit_wr_o = st_q.wr;
    assign unit_rd_o = st_q.rd;
    assign unit_rdata_force_o = `PDC_HALTED_RDATA;
    assign unit_rdata_forced_o = st_q.forced;
    assign clk_pin_o = st_q.clk_pin;
    assign clk_pin_oe_o = st_q.clk_oe;
endmodule // power_down_control

`default_nettype wire

// ---- pdc_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// Power-down checker
// ************************************************************
module pdc_sva (
    // Clock, reset and pins
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic deep_sleep_pin_n_i,
    input wire logic chip_init_pin_n_i,
    input wire pdc_pkg::pdc_acc_s unit_acc_i,
    // Design outputs
    input wire logic [7:0] unit_halt_control_o,
    input wire pdc_pkg::pdc_mode_e mode_o,
    input wire logic cpu_reset_o,
    input wire logic reset_exception_o,
    input wire logic osc_run_o,
    input wire logic ports_hiz_o,
    input wire logic ports_hold_o,
    input wire pdc_pkg::pdc_unit_s unit_o,
    input wire logic unit_rd_o,
    input wire logic unit_rdata_forced_o,
    input wire logic clk_pin_o,
    input wire logic clk_pin_oe_o
);
    import pdc_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_hw_float: assert property (
        mode_o == PDC_HW_DEEP_SLEEP_PIN_N && $stable(mode_o)
        |-> ports_hiz_o && cpu_reset_o && !clk_pin_oe_o)
        else $error("hw standby");
    a_enter_hw: assert property (
        $fell(deep_sleep_pin_n_i) |-> ##[2:4] mode_o == PDC_HW_DEEP_SLEEP_PIN_N)
        else $error("no hw standby");
    a_osc_start: assert property (
        $rose(deep_sleep_pin_n_i) && !chip_init_pin_n_i
        |-> ##[2:4] osc_run_o) else $error("no osc start");
    a_reset_exc: assert property (
        $rose(chip_init_pin_n_i) && mode_o == PDC_OSC_WAIT
        |-> ##[2:4] reset_exception_o ##1 !reset_exception_o)
        else $error("exc");
    a_halt_map: assert property (
        $changed(unit_halt_control_o) |-> ##[0:2]
        unit_o.halt == {unit_halt_control_o[5:3], unit_halt_control_o[0]})
        else $error("halt map");
    a_forced_rd: assert property (
        unit_acc_i.rd && unit_o.halt[unit_acc_i.unit]
        |=> unit_rdata_forced_o && !unit_rd_o) else $error("halted read");
    a_clk_stop: assert property (
        unit_halt_control_o[7] && $past(unit_halt_control_o[7])
        |-> !clk_pin_oe_o) else $error("clock pin driven");
    a_sw_hold: assert property (
        mode_o == PDC_SW_DEEP_SLEEP_PIN_N && $stable(mode_o)
        |-> ports_hold_o && !ports_hiz_o
        && (unit_halt_control_o[7] || clk_pin_oe_o && clk_pin_o))
        else $error("sw hold");
endmodule // pdc_sva
`default_nettype wire

// ---- pdc_supervisor.sv ----
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// Board supervisor: one full hardware standby cycle per request
// ************************************************************
module pdc_supervisor #(
    parameter int SETTLE = 12
) (
    input wire logic clk_i,
    input wire logic go_i,
    output logic deep_sleep_pin_n_o,
    output logic chip_init_pin_n_o,
    output logic busy_o
);
    initial begin
        deep_sleep_pin_n_o = 1'b1;
        chip_init_pin_n_o = 1'b1;
        busy_o = 1'b0;
    end
    always @(posedge clk_i) begin
        if (go_i && !busy_o) begin
            #1 busy_o = 1'b1;
            chip_init_pin_n_o = 1'b0;
            repeat (6) @(posedge clk_i);
            #1 deep_sleep_pin_n_o = 1'b0;
            repeat (8) @(posedge clk_i);
            #1 deep_sleep_pin_n_o = 1'b1;
            // The settle time is short, as the block counts no wait.
            repeat (SETTLE) @(posedge clk_i);
            #1 chip_init_pin_n_o = 1'b1;
            busy_o = 1'b0;
        end
    end
endmodule // pdc_supervisor
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import pdc_pkg::*;
    logic clk_i, sys_rst_i, sleep_req_i, sw_deep_sleep_pin_n_req_i, wake_i, phi_i, go;
    logic halt_ctrl_wr_i, busy, cpu_halt_o, cpu_reset_o, reset_exception_o;
    logic osc_run_o, ports_hiz_o, ports_hold_o, ram_keep_o, unit_wr_o;
    logic unit_rd_o, unit_rdata_forced_o, clk_pin_o, clk_pin_oe_o;
    wire logic deep_sleep_pin_n_i, chip_init_pin_n_i;
    logic [2:0] boot_config_pins_i, boot_config_o;
    logic [7:0] halt_ctrl_wdata_i, unit_halt_control_o, unit_rdata_force_o, v;
    logic [3:0] last_halt;
    pdc_acc_s unit_acc_i;
    pdc_mode_e mode_o, last_mode;
    pdc_unit_s unit_o;
    int num_errors, checks, seed, k;
    logic [7:0] mode_q[$], halt_q[$];
    power_down_control power_down_control_i (.*);
    pdc_supervisor pdc_supervisor_i (.clk_i(clk_i), .go_i(go), .busy_o(busy),
        .deep_sleep_pin_n_o(deep_sleep_pin_n_i),
        .chip_init_pin_n_o(chip_init_pin_n_i));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) phi_i <= #1 ~phi_i;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] d);
        halt_ctrl_wr_i = 1'b1;
        halt_ctrl_wdata_i = d;
        cyc(1);
        halt_ctrl_wr_i = 1'b0;
        cyc(3);
    endtask
    task automatic standby;
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        // Let the supervisor raise busy before it is polled.
        cyc(1);
        for (k = 0; k < 300 && busy !== 1'b0; k++) cyc(1);
        if (k == 300) begin
            num_errors++;
            conclude();
        end
        cyc(6);
        chk({5'h0, boot_config_o}, 8'h05);
    endtask
    // ************************************************************
    // Result watcher
    // ************************************************************
    always @(posedge clk_i) begin
        if (!sys_rst_i && mode_o !== last_mode)
            chk({3'h0, mode_o}, mode_q.pop_front());
        if (!sys_rst_i && unit_o.halt !== last_halt)
            chk({4'h0, unit_o.halt}, halt_q.pop_front());
        last_mode <= mode_o;
        last_halt <= unit_o.halt;
    end
    initial begin
        {num_errors, checks, k, go, phi_i, sleep_req_i, wake_i} = '0;
        {sw_deep_sleep_pin_n_req_i, halt_ctrl_wr_i, halt_ctrl_wdata_i, unit_acc_i, v} = '0;
        seed = 21314;
        sys_rst_i = 1'b1;
        boot_config_pins_i = 3'h5;
        last_mode = PDC_RUN;
        last_halt = 4'h0;
        cyc(2);
        sys_rst_i = 1'b0;
        cyc(3);
        chk(unit_halt_control_o, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            k = $random(seed);
            v = (i == 6) ? 8'h00 : v ^ (8'(k) & 8'h39);
            if (v[5:3] != unit_o.halt[3:1] || v[0] != unit_o.halt[0])
                halt_q.push_back({4'h0, v[5:3], v[0]});
            wr(v);
            for (int u = 0; u < 4; u++) begin
                unit_acc_i = '{1'b0, 1'b1, 2'(u), 8'(k)};
                cyc(1);
                chk({7'h0, unit_rdata_forced_o},
                    {7'h0, v[u == 0 ? 0 : u + 2]});
            end
            unit_acc_i = '0;
        end
        $display("test unit halt done");
        wr(8'h80);
        chk({7'h0, clk_pin_oe_o}, 8'h00);
        wr(8'h00);
        chk({7'h0, clk_pin_oe_o}, 8'h01);
        mode_q = '{{3'h0, PDC_SLEEP}, {3'h0, PDC_RUN}};
        sleep_req_i = 1'b1;
        cyc(1);
        sleep_req_i = 1'b0;
        cyc(3);
        wr(8'h39);
        chk({4'h0, unit_o.halt}, 8'h00);
        wake_i = 1'b1;
        cyc(1);
        wake_i = 1'b0;
        cyc(4);
        $display("test sleep done");
        mode_q = '{8'h04, 8'h01, 8'h08, 8'h10, 8'h01};
        sw_deep_sleep_pin_n_req_i = 1'b1;
        cyc(1);
        sw_deep_sleep_pin_n_req_i = 1'b0;
        cyc(4);
        chk({6'h0, cpu_halt_o, ram_keep_o}, 8'h03);
        standby();
        halt_q = '{8'h0F, 8'h00};
        wr(8'h39);
        mode_q = '{8'h08, 8'h10, 8'h01};
        standby();
        chk(unit_halt_control_o, 8'h00);
        $display("test hw standby done");
        chk(8'(mode_q.size() + halt_q.size()), 8'h00);
        conclude();
    end
endmodule // tb_top
bind power_down_control pdc_sva pdc_sva_i (.*);
`default_nettype wire
